// *** aomm_defines.svh ***
// Offsets, field positions, reset values and counts of the output map
`ifndef AOMM_DEFINES_SVH
`define AOMM_DEFINES_SVH
`define AOMM_WORDS       62
`define AOMM_A_STAT      6'h00
`define AOMM_A_VAL0      6'h01
`define AOMM_A_SCL_ST    6'h09
`define AOMM_A_CLF_ST    6'h0A
`define AOMM_A_ACC_ST    6'h0B
`define AOMM_A_RDPTR     6'h0C
`define AOMM_A_SCL_RQ    6'h0D
`define AOMM_A_CLF_RQ    6'h0E
`define AOMM_A_ACC_RQ    6'h0F
`define AOMM_A_SPEED     6'h10
`define AOMM_A_SLO0      6'h11
`define AOMM_A_SHI0      6'h19
`define AOMM_A_RAMP0     6'h21
`define AOMM_A_CLMP0     6'h29
`define AOMM_A_BAD_ADR   6'h39
`define AOMM_A_BAD_COD   6'h3A
`define AOMM_A_NV_TOT    6'h3B
`define AOMM_A_NV_RES    6'h3C
`define AOMM_A_NV_SET    6'h3D
`define AOMM_IO_CTRL     2'h0
`define AOMM_IO_DATA     2'h1
`define AOMM_IO_RDAT     2'h2
`define AOMM_IO_STAT     2'h3
`define AOMM_CTL_NV      0
`define AOMM_CTL_ADR_LSB 8
`define AOMM_CTL_RST     16'h0000
`define AOMM_SPEED_FAST  0
`define AOMM_INV_BIT     15
`define AOMM_UNI_LO      16'sh0000
`define AOMM_UNI_HI      16'sh0FFF
`define AOMM_BI_LO       16'shF800
`define AOMM_BI_HI       16'sh07FF
`define AOMM_NV_WARN1    16'h1388
`define AOMM_NV_WARN2    16'h2710
`define AOMM_BAD_RO      16'h0001
`define AOMM_BAD_UNMAP   16'h0002
`define AOMM_RES_OK      16'h0000
`define AOMM_RES_BUSY    16'h0001
`define AOMM_BLINK_MS    500
`define AOMM_CLK_KHZ     200000
`endif

// *** aomm_pkg.sv ***
// Types shared by the analog output map
package aomm_pkg;
    typedef enum logic [1:0] {S_LOAD, S_RUN, S_STORE, S_HALT} aomm_state_t;
endpackage

// *** aomm_map.sv ***
// Memory map, status and indicators of an eight-point analog output module
// Function
// RULE1: Run lamp lit in normal operation; dark and halted after an error.
// RULE2: Run lamp flashes once nonvolatile write count reaches 5,000 or 10,000.
// RULE3: Unipolar fixed range: range lamp lit below 0 or above 4095.
// RULE4: Bipolar fixed range: range lamp lit below -2048 or above 2047.
// RULE5: Scaled point: range lamp lit outside its scaling limits.
// RULE6: Internal map of 62 words: data, parameters and status.
// RULE7: Occupies two or four host I/O words, chosen by operating mode.
// RULE8: Two-word mode: host writes outputs 01-08 directly by block access.
// RULE9: Four-word mode: host reaches the map only through the I/O words.
// RULE10: With scaling, host sends values between the point's scaling limits.
// RULE11: Store flag rising copies the map to nonvolatile memory; loaded at start.
// RULE12: Word 00 reports invalid-data and conversion error flags.
// RULE13: Words 09-11 show accepted scaling, ramp, limit, format, enable states.
// RULE14: Host writes the enable requests into words 13-15.
// RULE15: Host selects conversion speed in word 16.
// RULE16: Host supplies scaling lower and upper limits in words 17-32.
// RULE17: Host supplies a ramp time per point in words 33-40.
// RULE18: Host supplies output clamp limits in words 41-56.
// RULE19: Words 57-60 report bad address, bad code, write count, write result.
// RULE20: Word 61, the write count setting, is read and written by both.
// RULE21: Range lamp lit while any point is out of range, else dark; the code keeps it dark while loading or halted.
`timescale 1ns/100ps
`include "aomm_defines.svh"
module aomm_map
    import aomm_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYC = `AOMM_BLINK_MS * `AOMM_CLK_KHZ
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Straps
    input  wire logic        four_word_mode,
    input  wire logic        nv_image_ok,
    input  wire logic [7:0]  range_bipolar,
    // Direct block access
    input  wire logic        blk_req,
    input  wire logic        blk_we,
    input  wire logic [5:0]  blk_addr,
    input  wire logic [15:0] blk_wdata,
    output logic             blk_ack,
    output logic      [15:0] blk_rdata,
    // Allocated I/O words
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [1:0]  io_sel,
    input  wire logic [15:0] io_wdata,
    output logic      [15:0] io_rdata,
    // Indicators
    output logic             run_led,
    output logic             range_led
);

    aomm_state_t state_q;
    aomm_state_t state_d;
    logic [5:0]  idx_q;
    logic        mode4_q;
    logic [15:0] ram_q [0:`AOMM_WORDS-1];
    logic [15:0] nv_q  [0:`AOMM_WORDS-1];
    logic [15:0] ctl_q;
    logic [5:0]  tgt_q;
    logic        nv_prev_q;
    logic        nv_req_q;
    logic [15:0] total_q;
    logic [15:0] res_q;
    logic        inv_q;
    logic [15:0] bad_adr_q;
    logic [15:0] bad_cod_q;
    logic        blk_ack_q;
    logic [15:0] blk_rdata_q;
    logic [15:0] io_rdata_q;
    logic [31:0] blink_cnt_q;
    logic        blink_q;
    logic        run_led_q;
    logic        range_q;
    logic [7:0]  oor;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Host access decode
    wire        active     = (state_q == S_RUN) | (state_q == S_STORE);
    wire        blk_go     = blk_req & ~mode4_q & (state_q != S_LOAD);
    wire        io_data_wr = io_wr & mode4_q & (io_sel == `AOMM_IO_DATA);
    wire        ctl_wr     = io_wr & active & (io_sel == `AOMM_IO_CTRL);
    wire        wr_req     = active & ((blk_go & blk_we) | io_data_wr);
    wire [5:0]  wr_adr     = mode4_q ? tgt_q : blk_addr;
    wire [15:0] wr_dat     = mode4_q ? io_wdata : blk_wdata;
    wire        adr_unmap  = wr_adr > `AOMM_A_NV_SET;
    wire        adr_ro     = (wr_adr == `AOMM_A_STAT) |
                             ((wr_adr >= `AOMM_A_SCL_ST) &
                              (wr_adr <= `AOMM_A_ACC_ST)) |
                             ((wr_adr >= `AOMM_A_BAD_ADR) &
                              (wr_adr <= `AOMM_A_NV_RES));
    wire        wr_ok      = wr_req & ~adr_ro & ~adr_unmap;
    wire        wr_bad     = wr_req & (adr_ro | adr_unmap);
    wire        ptr_inc    = active & mode4_q & io_rd &
                             (io_sel == `AOMM_IO_RDAT);
    wire        ld_we      = state_q == S_LOAD;
    wire        idx_last   = idx_q == `AOMM_A_NV_SET;
    wire [15:0] ld_dat     = nv_image_ok ? nv_q[idx_q] : 16'h0000;

    // Accepted settings; high speed excludes scaling, ramp and clamp
    wire       fast    = ram_q[`AOMM_A_SPEED][`AOMM_SPEED_FAST]; // RULE15
    wire [7:0] scl_en  = ram_q[`AOMM_A_SCL_RQ][7:0] & {8{~fast}}; // RULE14
    wire [7:0] ramp_en = ram_q[`AOMM_A_SCL_RQ][15:8] & {8{~fast}};
    wire [7:0] lim_en  = ram_q[`AOMM_A_CLF_RQ][7:0] & {8{~fast}};
    wire [7:0] fmt_bin = ram_q[`AOMM_A_CLF_RQ][15:8];
    wire [7:0] val_en  = ram_q[`AOMM_A_ACC_RQ][7:0];
    wire       flash   = total_q >= `AOMM_NV_WARN1; // RULE2

    // Status words
    wire [15:0] w_stat = {inv_q, 7'h00, oor}; // RULE12
    wire [15:0] w_scl  = {ramp_en, scl_en}; // RULE13
    wire [15:0] w_clf  = {fmt_bin, lim_en}; // RULE13
    wire [15:0] w_acc  = {8'h00, val_en}; // RULE13

    // Per-point range check; reversed limits are allowed
    for (genvar i = 0; i < 8; i++) begin : g_pt
        wire signed [15:0] v  = ram_q[`AOMM_A_VAL0 + i];
        wire signed [15:0] lo = ram_q[`AOMM_A_SLO0 + i]; // RULE16
        wire signed [15:0] hi = ram_q[`AOMM_A_SHI0 + i]; // RULE16
        wire signed [15:0] mn = (lo < hi) ? lo : hi;
        wire signed [15:0] mx = (lo < hi) ? hi : lo;
        wire oor_scl = (v < mn) | (v > mx); // RULE5 RULE10
        wire oor_bi  = (v < `AOMM_BI_LO) | (v > `AOMM_BI_HI); // RULE4
        wire oor_uni = (v < `AOMM_UNI_LO) | (v > `AOMM_UNI_HI); // RULE3
        assign oor[i] = scl_en[i] ? oor_scl :
                        range_bipolar[i] ? oor_bi : oor_uni;
    end

    function automatic logic [15:0] map_rd(input logic [5:0] a);
        case (a)
            `AOMM_A_STAT:    map_rd = w_stat;
            `AOMM_A_SCL_ST:  map_rd = w_scl;
            `AOMM_A_CLF_ST:  map_rd = w_clf;
            `AOMM_A_ACC_ST:  map_rd = w_acc;
            `AOMM_A_BAD_ADR: map_rd = bad_adr_q; // RULE19
            `AOMM_A_BAD_COD: map_rd = bad_cod_q; // RULE19
            `AOMM_A_NV_TOT:  map_rd = total_q; // RULE19
            `AOMM_A_NV_RES:  map_rd = res_q; // RULE19
            `AOMM_A_NV_SET:  map_rd = total_q; // RULE20
            default: map_rd = (a <= `AOMM_A_NV_SET) ? ram_q[a] : 16'h0000;
        endcase
    endfunction

    // Two-word mode exposes only control and status
    wire [15:0] io_val =
        (io_sel == `AOMM_IO_CTRL) ? ctl_q :
        !mode4_q ? ((io_sel == `AOMM_IO_DATA) ? w_stat : 16'h0000) :
        (io_sel == `AOMM_IO_DATA) ? map_rd(tgt_q) :
        (io_sel == `AOMM_IO_RDAT) ? map_rd(ram_q[`AOMM_A_RDPTR][5:0]) :
        w_stat; // RULE7 RULE9

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_LOAD: begin
                if (idx_last) state_d = S_RUN;
            end
            S_RUN: begin
                if (wr_bad) state_d = S_HALT; // RULE1
                else if (nv_req_q) state_d = S_STORE; // RULE11
            end
            S_STORE: begin
                if (wr_bad) state_d = S_HALT; // RULE1
                else if (idx_last) state_d = S_RUN;
            end
            S_HALT: state_d = S_HALT;
            default: state_d = S_LOAD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_LOAD;
            idx_q   <= 6'h00;
        end else begin
            state_q <= state_d;
            if ((ld_we | (state_q == S_STORE)) & ~wr_bad)
                idx_q <= idx_last ? 6'h00 : idx_q + 6'h01;
        end
    end

    // Strap caught while loading, after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) mode4_q <= 1'b0;
        else if (ld_we) mode4_q <= four_word_mode; // RULE7
    end

    // Map storage; memories carry no reset
    always_ff @(posedge clk) begin
        if (ld_we) ram_q[idx_q] <= ld_dat; // RULE6 RULE11
        else if (wr_ok) ram_q[wr_adr] <= wr_dat; // RULE6 RULE8 RULE9
        else if (ptr_inc)
            ram_q[`AOMM_A_RDPTR] <= ram_q[`AOMM_A_RDPTR] + 16'h0001;
    end

    always_ff @(posedge clk) begin
        if (state_q == S_STORE)
            nv_q[idx_q] <= idx_last ? total_q + 16'h0001
                                    : map_rd(idx_q); // RULE11
    end

    // Control word and store request; the request edge wins over its clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q     <= `AOMM_CTL_RST;
            tgt_q     <= 6'h00;
            nv_prev_q <= 1'b0;
            nv_req_q  <= 1'b0;
        end else begin
            if (ctl_wr) begin
                ctl_q <= io_wdata;
                tgt_q <= io_wdata[`AOMM_CTL_ADR_LSB +: 6];
            end else if (io_data_wr & active) begin
                tgt_q <= tgt_q + 6'h01;
            end
            nv_prev_q <= ctl_q[`AOMM_CTL_NV];
            nv_req_q  <= (ctl_q[`AOMM_CTL_NV] & ~nv_prev_q) |
                         (nv_req_q & (state_q != S_RUN)); // RULE11
        end
    end

    // Write count and result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            total_q <= 16'h0000;
            res_q   <= `AOMM_RES_OK;
        end else begin
            if (ld_we & idx_last) total_q <= ld_dat;
            else if ((state_q == S_STORE) & idx_last)
                total_q <= total_q + 16'h0001; // RULE19
            else if (wr_ok & (wr_adr == `AOMM_A_NV_SET))
                total_q <= wr_dat; // RULE20
            if ((state_q == S_RUN) & (state_d == S_STORE))
                res_q <= `AOMM_RES_BUSY;
            else if ((state_q == S_STORE) & idx_last)
                res_q <= `AOMM_RES_OK; // RULE19
        end
    end

    // First bad write is kept; later ones cannot arrive once halted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inv_q     <= 1'b0;
            bad_adr_q <= 16'h0000;
            bad_cod_q <= 16'h0000;
        end else if (wr_bad) begin
            inv_q     <= 1'b1; // RULE12
            bad_adr_q <= {10'h000, wr_adr}; // RULE19
            bad_cod_q <= adr_unmap ? `AOMM_BAD_UNMAP : `AOMM_BAD_RO;
        end
    end

    // Host answers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_ack_q   <= 1'b0;
            blk_rdata_q <= 16'h0000;
            io_rdata_q  <= 16'h0000;
        end else begin
            blk_ack_q <= blk_go; // RULE8
            if (blk_go & ~blk_we) blk_rdata_q <= map_rd(blk_addr);
            if (io_rd) io_rdata_q <= io_val;
        end
    end

    // Indicators
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_q <= 32'h00000000;
            blink_q     <= 1'b0;
            run_led_q   <= 1'b0;
            range_q     <= 1'b0;
        end else begin
            if (!flash) begin
                blink_cnt_q <= 32'h00000000;
                blink_q     <= 1'b0;
            end else if (blink_cnt_q == BLINK_HALF_CYC - 1) begin
                blink_cnt_q <= 32'h00000000;
                blink_q     <= ~blink_q; // RULE2
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h00000001;
            end
            run_led_q <= ((state_d == S_RUN) | (state_d == S_STORE)) &
                         (~flash | blink_q); // RULE1 RULE2
            range_q   <= active & (|oor); // RULE21
        end
    end

    assign blk_ack   = blk_ack_q;
    assign blk_rdata = blk_rdata_q;
    assign io_rdata  = io_rdata_q;
    assign run_led   = run_led_q;
    assign range_led = range_q;

    // Checks

    property p_run_halt;
        wr_bad |=> (state_q == S_HALT && !run_led)[*3];
    endproperty
    a_run_halt: assert property (p_run_halt) // RULE1
        else $error("run lamp not dark after error");

    property p_run_dark_phase;
        (state_q == S_RUN && flash && !blink_q && !wr_bad && !nv_req_q &&
         blink_cnt_q != BLINK_HALF_CYC - 1) |=> !run_led;
    endproperty
    a_run_dark_phase: assert property (p_run_dark_phase) // RULE2
        else $error("run lamp not flashing at high write count");

    property p_uni;
        (!scl_en[1] && !range_bipolar[1] &&
         $signed(ram_q[`AOMM_A_VAL0 + 1]) > `AOMM_UNI_HI) |-> oor[1];
    endproperty
    a_uni: assert property (p_uni) // RULE3
        else $error("unipolar over-range missed");

    property p_bi;
        (!scl_en[2] && range_bipolar[2] &&
         $signed(ram_q[`AOMM_A_VAL0 + 2]) >= `AOMM_BI_LO &&
         $signed(ram_q[`AOMM_A_VAL0 + 2]) <= `AOMM_BI_HI) |-> !oor[2];
    endproperty
    a_bi: assert property (p_bi) // RULE4
        else $error("bipolar in-range flagged");

    property p_scl;
        (scl_en[4] && $signed(ram_q[`AOMM_A_VAL0 + 4]) >
         $signed(ram_q[`AOMM_A_SLO0 + 4]) &&
         $signed(ram_q[`AOMM_A_VAL0 + 4]) >
         $signed(ram_q[`AOMM_A_SHI0 + 4])) |-> oor[4];
    endproperty
    a_scl: assert property (p_scl) // RULE5
        else $error("scaled over-range missed");

    property p_range;
        (active && |oor && !wr_bad) |=> range_led;
    endproperty
    a_range: assert property (p_range) // RULE21
        else $error("range lamp dark with a point out of range");

    property p_store;
        (state_q == S_RUN && nv_req_q && !wr_bad) |=>
            (state_q == S_STORE && res_q == `AOMM_RES_BUSY)[*8];
    endproperty
    a_store: assert property (p_store) // RULE11
        else $error("store did not start");

    property p_count;
        (state_q == S_STORE && idx_last) |=>
            total_q == $past(total_q) + 16'h0001 && res_q == `AOMM_RES_OK;
    endproperty
    a_count: assert property (p_count) // RULE19
        else $error("write count not advanced");

    property p_two;
        (state_q == S_RUN && blk_req && blk_we && !mode4_q &&
         blk_addr == `AOMM_A_VAL0) |=>
            ram_q[`AOMM_A_VAL0] == $past(blk_wdata) && blk_ack;
    endproperty
    a_two: assert property (p_two) // RULE8
        else $error("direct write lost");

    property p_four;
        (blk_req && mode4_q) |=> !blk_ack;
    endproperty
    a_four: assert property (p_four) // RULE9
        else $error("block access answered in four-word mode");

    property p_io2;
        (io_rd && !mode4_q && io_sel[1]) |=> io_rdata == 16'h0000;
    endproperty
    a_io2: assert property (p_io2) // RULE7
        else $error("extra I/O word live in two-word mode");

    property p_bad;
        wr_bad |=> w_stat[`AOMM_INV_BIT] &&
                   bad_adr_q[5:0] == $past(wr_adr);
    endproperty
    a_bad: assert property (p_bad) // RULE12
        else $error("invalid write not reported");

    property p_fast;
        fast |-> w_scl == 16'h0000 && w_clf[7:0] == 8'h00;
    endproperty
    a_fast: assert property (p_fast) // RULE13
        else $error("high speed shows enabled functions");

    property p_set;
        (state_q == S_RUN && wr_ok && wr_adr == `AOMM_A_NV_SET) |=>
            map_rd(`AOMM_A_NV_SET) == $past(wr_dat);
    endproperty
    a_set: assert property (p_set) // RULE20
        else $error("count setting not written");

    c_store: cover property (state_q == S_STORE ##1 state_q == S_RUN);
    c_halt: cover property (state_q == S_RUN ##1 state_q == S_HALT);
    c_flash: cover property (flash && run_led ##1 !run_led);
    c_four: cover property (io_data_wr && active && mode4_q);

endmodule // aomm_map

// *** aomm_host.sv ***
// Host controller model issuing block and I/O word accesses
`timescale 1ns/100ps
module aomm_host (
    // Clock
    input  wire logic        clk,
    // Direct block access
    output logic             blk_req,
    output logic             blk_we,
    output logic      [5:0]  blk_addr,
    output logic      [15:0] blk_wdata,
    input  wire logic        blk_ack,
    input  wire logic [15:0] blk_rdata,
    // Allocated I/O words
    output logic             io_wr,
    output logic             io_rd,
    output logic      [1:0]  io_sel,
    output logic      [15:0] io_wdata,
    input  wire logic [15:0] io_rdata
);
    initial begin
        blk_req   = 1'b0;
        blk_we    = 1'b0;
        blk_addr  = 6'h00;
        blk_wdata = 16'h0000;
        io_wr     = 1'b0;
        io_rd     = 1'b0;
        io_sel    = 2'h0;
        io_wdata  = 16'h0000;
    end

    // One-cycle block request, answer taken one edge later
    task automatic blk(input logic we, input logic [5:0] a,
                       input logic [15:0] d, output logic [15:0] rd,
                       output logic ack);
        @(posedge clk);
        #1;
        blk_req   = 1'b1;
        blk_we    = we;
        blk_addr  = a;
        blk_wdata = d;
        @(posedge clk);
        #1;
        blk_req   = 1'b0;
        ack       = blk_ack;
        rd        = blk_rdata;
        // Released lines must not keep a stale value
        blk_addr  = ~a;
        blk_wdata = ~d;
    endtask

    // One-cycle I/O word strobe
    task automatic io(input logic we, input logic [1:0] s,
                      input logic [15:0] d, output logic [15:0] rd);
        @(posedge clk);
        #1;
        io_wr    = we;
        io_rd    = ~we;
        io_sel   = s;
        io_wdata = d;
        @(posedge clk);
        #1;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        rd       = io_rdata;
        io_sel   = ~s;
        io_wdata = ~d;
    endtask
endmodule // aomm_host

// *** tb.sv ***
// Self-checking bench of the analog output map
`timescale 1ns/100ps
module tb;
    logic        clk;
    logic        rst_n;
    logic        four_word_mode;
    logic        nv_image_ok;
    logic        blk_req;
    logic        blk_we;
    logic [5:0]  blk_addr;
    logic [15:0] blk_wdata;
    logic        blk_ack;
    logic [15:0] blk_rdata;
    logic        io_wr;
    logic        io_rd;
    logic [1:0]  io_sel;
    logic [15:0] io_wdata;
    logic [15:0] io_rdata;
    logic        run_led;
    logic        range_led;
    int          mismatches;
    int          checks_done;

    aomm_map #(.BLINK_HALF_CYC(8)) DUT (
        .clk(clk), .rst_n(rst_n), .four_word_mode(four_word_mode),
        .nv_image_ok(nv_image_ok), .range_bipolar(8'h04),
        .blk_req(blk_req), .blk_we(blk_we), .blk_addr(blk_addr),
        .blk_wdata(blk_wdata), .blk_ack(blk_ack), .blk_rdata(blk_rdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_sel(io_sel),
        .io_wdata(io_wdata), .io_rdata(io_rdata),
        .run_led(run_led), .range_led(range_led));

    aomm_host host (
        .clk(clk), .blk_req(blk_req), .blk_we(blk_we),
        .blk_addr(blk_addr), .blk_wdata(blk_wdata), .blk_ack(blk_ack),
        .blk_rdata(blk_rdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_sel(io_sel), .io_wdata(io_wdata), .io_rdata(io_rdata));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic        k;
        host.blk(1'b1, a, d, r, k);
        chk("block write ack", {15'h0000, k}, 16'h0001);
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] r;
        logic        k;
        host.blk(1'b0, a, 16'h0000, r, k);
        chk("block read ack", {15'h0000, k}, 16'h0001);
        chk("block read data", r, e);
    endtask

    task automatic range_is(input logic e);
        tick(1);
        chk("range lamp", {15'h0000, range_led}, {15'h0000, e});
    endtask

    // Counts lit cycles of the run lamp over a span
    task automatic run_ones(input int n, input int e);
        int c;
        c = 0;
        repeat (n) begin
            tick(1);
            c += (run_led === 1'b1);
        end
        chk("run lamp lit cycles", c[15:0], e[15:0]);
    endtask

    task automatic do_reset(input logic mode);
        #1;
        rst_n = 1'b0;
        four_word_mode = mode;
        tick(5);
        rst_n = 1'b1;
        tick(63);
    endtask

    task automatic t_basic;
        chk("run lamp after load", {15'h0000, run_led}, 16'h0001);
        chk("range lamp idle", {15'h0000, range_led}, 16'h0000);
        wr(6'h01, 16'h0FFF);
        rd(6'h01, 16'h0FFF);
        wr(6'h21, 16'h1234);
        wr(6'h29, 16'h0A0A);
        rd(6'h21, 16'h1234);
        rd(6'h29, 16'h0A0A);
    endtask

    task automatic t_range;
        logic [15:0] r;
        wr(6'h02, 16'h1000);
        range_is(1'b1);
        rd(6'h00, 16'h0002);
        host.io(1'b0, 2'h1, 16'h0000, r);
        chk("status via io", r, 16'h0002);
        host.io(1'b0, 2'h2, 16'h0000, r);
        chk("unused io word", r, 16'h0000);
        wr(6'h02, 16'h0000);
        range_is(1'b0);
        wr(6'h03, 16'hF800);
        range_is(1'b0);
        wr(6'h03, 16'hF7FF);
        range_is(1'b1);
        wr(6'h03, 16'h07FF);
        range_is(1'b0);
        wr(6'h03, 16'h0800);
        range_is(1'b1);
        wr(6'h03, 16'h0000);
        range_is(1'b0);
    endtask

    task automatic t_scale;
        wr(6'h0D, 16'h0010);
        wr(6'h15, 16'h0064);
        wr(6'h1D, 16'h00C8);
        wr(6'h05, 16'h0096);
        range_is(1'b0);
        rd(6'h09, 16'h0010);
        wr(6'h05, 16'h00FA);
        range_is(1'b1);
        wr(6'h05, 16'h0032);
        range_is(1'b1);
        wr(6'h10, 16'h0001);
        rd(6'h09, 16'h0000);
        range_is(1'b0);
    endtask

    task automatic t_store;
        logic [15:0] r;
        wr(6'h3D, 16'h1387);
        rd(6'h3B, 16'h1387);
        host.io(1'b1, 2'h0, 16'h0001, r);
        tick(3);
        rd(6'h3C, 16'h0001);
        tick(70);
        rd(6'h3B, 16'h1388);
        rd(6'h3C, 16'h0000);
        rd(6'h3D, 16'h1388);
        run_ones(32, 16);
    endtask

    task automatic t_error;
        wr(6'h09, 16'h00FF);
        tick(2);
        run_ones(16, 0);
        rd(6'h00, 16'h8000);
        rd(6'h39, 16'h0009);
        rd(6'h3A, 16'h0001);
        wr(6'h01, 16'h0123);
        rd(6'h01, 16'h0FFF);
    endtask

    task automatic t_four;
        logic [15:0] r;
        logic        k;
        // Reload the image stored earlier in the run
        nv_image_ok = 1'b1;
        do_reset(1'b1);
        host.blk(1'b1, 6'h01, 16'h0555, r, k);
        chk("block refused", {15'h0000, k}, 16'h0000);
        host.io(1'b1, 2'h0, 16'h0100, r);
        host.io(1'b1, 2'h1, 16'h0ABC, r);
        host.io(1'b1, 2'h0, 16'h0100, r);
        host.io(1'b0, 2'h1, 16'h0000, r);
        chk("io target read", r, 16'h0ABC);
        host.io(1'b1, 2'h0, 16'h0C00, r);
        host.io(1'b1, 2'h1, 16'h0001, r);
        host.io(1'b0, 2'h2, 16'h0000, r);
        chk("io pointer read", r, 16'h0ABC);
        host.io(1'b0, 2'h3, 16'h0000, r);
        chk("io status read", r, 16'h0000);
        host.io(1'b1, 2'h0, 16'h2100, r);
        host.io(1'b0, 2'h1, 16'h0000, r);
        chk("stored ramp time reloaded", r, 16'h1234);
        host.io(1'b1, 2'h0, 16'h3B00, r);
        host.io(1'b0, 2'h1, 16'h0000, r);
        chk("stored write count reloaded", r, 16'h1388);
    endtask

    initial begin
        mismatches = 0;
        checks_done = 0;
        rst_n = 1'b0;
        four_word_mode = 1'b0;
        nv_image_ok = 1'b0;
        do_reset(1'b0);
        t_basic();
        t_range();
        t_scale();
        t_store();
        t_error();
        t_four();
        stop_test();
    end

    // Whole run needs about 370 cycles
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule // tb
